/* File: rtl/dual_pot_i2c_register_slave.sv */
// Serial-bus register slave for a dual 128-position potentiometer
// Notes on behaviour
// - Tap output equals position, 00h low, 7Fh high
// - Both wipers start at 40h
// - Addresses 0, 1 wipers; 10h control
// - Control bit 6 is active-low shutdown, both
// - Shutdown output asserted while bit is 0
// - Positions kept in shutdown, taps restored after
// - Brownout in shutdown resets wipers to mid-scale
// - Slave only; master starts and clocks transfers
// - Bytes travel most significant bit first
// - Data changes only while clock low
// - Data line released after power-up
// - Ignore traffic before START and during power-up
// - STOP returns link to idle standby
// - Receiver pulls data low on ninth clock
// - Acknowledge valid id, address and write data
// - Id is type code, pin levels, read bit
// - Write data loads on ninth clock
// - Extra write bytes go to next channel
// - Read via address, repeated START, read id
// - Sample on rising clock, drive after falling
`timescale 1ns/1ns
module dual_pot_i2c_register_slave
    import dual_pot_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_DEFAULT,
    parameter int BROWNOUT_CNT = BROWNOUT_CYCLES,
    parameter int POWERUP_CNT = POWERUP_CYCLES
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic addr_pin_2_in,
    input wire logic addr_pin_1_in,
    input wire logic addr_pin_0_in,
    input wire logic brownout_in,
    output logic [TAP_W-1:0] tap_sel_0_out,
    output logic [TAP_W-1:0] tap_sel_1_out,
    output logic shutdown_out
);

    localparam int BO_W = $clog2(BROWNOUT_CNT + 1);
    localparam int PU_W = $clog2(POWERUP_CNT + 1);
    localparam logic [BO_W-1:0] BO_LIMIT = BO_W'(BROWNOUT_CNT);
    localparam logic [PU_W-1:0] PU_LIMIT = PU_W'(POWERUP_CNT);

    // Byte returned for a register address, zero where nothing is mapped
    function automatic logic [7:0] read_value(input logic [7:0] addr,
            input logic [7:0] w0, input logic [7:0] w1, input logic run);
        logic [7:0] v;
        v = 8'h00;
        if (addr == ADDR_WIPER_0) begin
            v = w0;
        end else if (addr == ADDR_WIPER_1) begin
            v = w1;
        end else if (addr == ADDR_SHUTDOWN_CTRL) begin
            v[RUN_BIT] = run;
        end
        return v;
    endfunction

    // Read pointer walks every mapped register and wraps
    function automatic logic [7:0] next_read_addr(input logic [7:0] addr);
        logic [7:0] n;
        n = addr + 8'h01;
        if (addr == ADDR_WIPER_1) begin
            n = ADDR_SHUTDOWN_CTRL;
        end else if (addr == ADDR_SHUTDOWN_CTRL) begin
            n = ADDR_WIPER_0;
        end
        return n;
    endfunction

    // Further write bytes go to wiper 1 after wiper 0, and to wiper 0 after any other address
    function automatic logic [7:0] next_write_addr(input logic [7:0] addr);
        return (addr == ADDR_WIPER_0) ? ADDR_WIPER_1 : ADDR_WIPER_0;
    endfunction

    // ------------------------------------------------------------------
    // System clock domain: wiper and shutdown state, brownout, power-up
    // ------------------------------------------------------------------
    logic [7:0] wiper_reg [CHANNELS];
    logic run_not_shutdown_reg;
    logic bo_meta_reg, bo_sync_reg;
    logic [BO_W-1:0] bo_cnt_reg, bo_cnt_next;
    logic bo_fired_reg;
    logic bo_tgl_reg;
    logic [PU_W-1:0] pu_cnt_reg;
    logic pwr_ready_reg;
    logic wr_meta_reg, wr_sync_reg, wr_prev_reg;

    // Link-side signals that the system side reads
    logic wr_tgl_reg;
    wr_req_s wr_slot_reg [2];

    wire bo_active = bo_sync_reg & ~run_not_shutdown_reg;
    wire bo_reset = bo_active & ~bo_fired_reg & (bo_cnt_reg >= BO_LIMIT);
    wire wr_event = wr_sync_reg ^ wr_prev_reg;
    wr_req_s wr_apply;
    assign wr_apply = wr_slot_reg[wr_sync_reg];

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bo_meta_reg <= 1'b0;
            bo_sync_reg <= 1'b0;
            wr_meta_reg <= 1'b0;
            wr_sync_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
        end else begin
            bo_meta_reg <= brownout_in;
            bo_sync_reg <= bo_meta_reg;
            wr_meta_reg <= wr_tgl_reg;
            wr_sync_reg <= wr_meta_reg;
            wr_prev_reg <= wr_sync_reg;
        end
    end

    // Low supply must persist before it counts; one reset per dip
    assign bo_cnt_next = !bo_active ? '0 :
        (bo_cnt_reg >= BO_LIMIT) ? bo_cnt_reg : bo_cnt_reg + BO_W'(1);

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bo_cnt_reg <= '0;
            bo_fired_reg <= 1'b0;
            bo_tgl_reg <= 1'b0;
        end else begin
            bo_cnt_reg <= bo_cnt_next;
            bo_fired_reg <= bo_active & (bo_fired_reg | bo_reset);
            if (bo_reset) begin
                bo_tgl_reg <= ~bo_tgl_reg;
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pu_cnt_reg <= '0;
            pwr_ready_reg <= 1'b0;
        end else if (pu_cnt_reg < PU_LIMIT) begin
            pu_cnt_reg <= pu_cnt_reg + PU_W'(1);
        end else begin
            pwr_ready_reg <= 1'b1;
        end
    end

    // Brownout takes precedence over a write arriving in the same cycle
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wiper_reg[0] <= WIPER_RESET;
            wiper_reg[1] <= WIPER_RESET;
            run_not_shutdown_reg <= CTRL_RESET[RUN_BIT];
        end else if (bo_reset) begin
            wiper_reg[0] <= WIPER_RESET;
            wiper_reg[1] <= WIPER_RESET;
        end else if (wr_event) begin
            if (wr_apply.addr == ADDR_WIPER_0) begin
                wiper_reg[0] <= wr_apply.data & WIPER_MASK;
            end
            if (wr_apply.addr == ADDR_WIPER_1) begin
                wiper_reg[1] <= wr_apply.data & WIPER_MASK;
            end
            if (wr_apply.addr == ADDR_SHUTDOWN_CTRL) begin
                run_not_shutdown_reg <= wr_apply.data[RUN_BIT];
            end
        end
    end

    // Taps keep their stored values through shutdown
    assign tap_sel_0_out = wiper_reg[0][TAP_W-1:0];
    assign tap_sel_1_out = wiper_reg[1][TAP_W-1:0];
    assign shutdown_out = ~run_not_shutdown_reg;

    // ------------------------------------------------------------------
    // Bus-condition detectors, clocked by the data line itself
    // ------------------------------------------------------------------
    // Our own data changes happen only with the clock low, so these
    // see nothing but the master's START and STOP.
    logic start_tgl_reg, stop_tgl_reg;

    always_ff @(negedge sda_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_clk_in) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    always_ff @(posedge sda_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stop_tgl_reg <= 1'b0;
        end else if (scl_clk_in) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end

    // ------------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------------
    link_state_e state_reg, state_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic read_reg, read_next;
    logic start_seen_reg, stop_seen_reg;
    logic ready_meta_reg, ready_sync_reg;
    logic [2:0] pin_meta_reg, pin_sync_reg;
    logic bol_meta_reg, bol_sync_reg, bol_seen_reg;
    logic [7:0] shadow_reg [CHANNELS];
    logic shadow_run_reg;
    logic wr_fire;
    logic drive_reg, drive_next;

    // The toggle halves a flip since START and STOP are edges apart by
    // at least half a bus clock; the link edge that follows reads them.
    wire new_start = start_tgl_reg ^ start_seen_reg;
    wire stop_pending = stop_tgl_reg ^ stop_seen_reg;
    wire [7:0] sampled_byte = {shift_reg[6:0], sda_in};
    wire last_bit = (bit_cnt_reg == 3'd7);
    wire id_match = (sampled_byte[7:4] == DEVICE_TYPE) &&
        (sampled_byte[3:1] == pin_sync_reg);
    wire bol_event = bol_sync_reg ^ bol_seen_reg;
    wire [7:0] tx_byte = read_value(ptr_reg, shadow_reg[0], shadow_reg[1],
        shadow_run_reg);
    wr_req_s wr_req;
    assign wr_req = '{addr: ptr_reg, data: shift_reg};

    always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ready_meta_reg <= 1'b0;
            ready_sync_reg <= 1'b0;
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            bol_meta_reg <= 1'b0;
            bol_sync_reg <= 1'b0;
            bol_seen_reg <= 1'b0;
        end else begin
            ready_meta_reg <= pwr_ready_reg;
            ready_sync_reg <= ready_meta_reg;
            pin_meta_reg <= {addr_pin_2_in, addr_pin_1_in, addr_pin_0_in};
            pin_sync_reg <= pin_meta_reg;
            bol_meta_reg <= bo_tgl_reg;
            bol_sync_reg <= bol_meta_reg;
            bol_seen_reg <= bol_sync_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg + 3'd1;
        shift_next = sampled_byte;
        ptr_next = ptr_reg;
        read_next = read_reg;
        wr_fire = 1'b0;
        if (new_start) begin
            // Also covers a repeated START in mid-transfer
            state_next = ready_sync_reg ? ST_ID : ST_IDLE;
            bit_cnt_next = 3'd1;
            shift_next = {7'h00, sda_in};
        end else if (stop_pending) begin
            state_next = ST_IDLE;
            bit_cnt_next = 3'd0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    bit_cnt_next = 3'd0;
                end
                ST_ID: begin
                    if (last_bit) begin
                        state_next = id_match ? ST_ID_ACK : ST_IDLE;
                        read_next = sampled_byte[ID_RW_BIT];
                    end
                end
                ST_ID_ACK: begin
                    state_next = read_reg ? ST_RDATA : ST_ADDR;
                    bit_cnt_next = 3'd0;
                end
                ST_ADDR: begin
                    if (last_bit) begin
                        state_next = ST_ADDR_ACK;
                        ptr_next = sampled_byte;
                    end
                end
                ST_ADDR_ACK: begin
                    state_next = ST_WDATA;
                    bit_cnt_next = 3'd0;
                end
                ST_WDATA: begin
                    if (last_bit) begin
                        state_next = ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK: begin
                    wr_fire = 1'b1;
                    ptr_next = next_write_addr(ptr_reg);
                    state_next = ST_WDATA;
                    bit_cnt_next = 3'd0;
                end
                ST_RDATA: begin
                    if (last_bit) begin
                        state_next = ST_RDATA_ACK;
                    end
                end
                ST_RDATA_ACK: begin
                    bit_cnt_next = 3'd0;
                    if (sda_in) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_RDATA;
                        ptr_next = next_read_addr(ptr_reg);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 3'd0;
            shift_reg <= 8'h00;
            ptr_reg <= ADDR_WIPER_0;
            read_reg <= 1'b0;
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            read_reg <= read_next;
            start_seen_reg <= start_tgl_reg;
            stop_seen_reg <= stop_tgl_reg;
        end
    end

    // Writes cross in two slots; a slot is reused only two writes later,
    // long after the system side has taken it.
    always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_tgl_reg <= 1'b0;
            wr_slot_reg[0] <= '0;
            wr_slot_reg[1] <= '0;
        end else if (wr_fire) begin
            wr_slot_reg[~wr_tgl_reg] <= wr_req;
            wr_tgl_reg <= ~wr_tgl_reg;
        end
    end

    // Link-side copy of the registers serves reads without a crossing;
    // a write on the same edge as a brownout notice is the newer value.
    always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shadow_reg[0] <= WIPER_RESET;
            shadow_reg[1] <= WIPER_RESET;
            shadow_run_reg <= CTRL_RESET[RUN_BIT];
        end else begin
            if (bol_event) begin
                shadow_reg[0] <= WIPER_RESET;
                shadow_reg[1] <= WIPER_RESET;
            end
            if (wr_fire && wr_req.addr == ADDR_WIPER_0) begin
                shadow_reg[0] <= wr_req.data & WIPER_MASK;
            end
            if (wr_fire && wr_req.addr == ADDR_WIPER_1) begin
                shadow_reg[1] <= wr_req.data & WIPER_MASK;
            end
            if (wr_fire && wr_req.addr == ADDR_SHUTDOWN_CTRL) begin
                shadow_run_reg <= wr_req.data[RUN_BIT];
            end
        end
    end

    // Data line is changed only on the falling clock edge
    always_comb begin
        drive_next = 1'b0;
        if (!new_start && !stop_pending) begin
            unique case (state_reg)
                ST_ID_ACK, ST_ADDR_ACK, ST_WDATA_ACK: begin
                    drive_next = 1'b1;
                end
                ST_RDATA: begin
                    drive_next = ~tx_byte[~bit_cnt_reg];
                end
                ST_IDLE, ST_ID, ST_ADDR, ST_WDATA, ST_RDATA_ACK: begin
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(negedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_out = drive_reg;

endmodule

/* File: rtl/dual_pot_pkg.sv */
// Shared constants and types for the dual potentiometer register slave
package dual_pot_pkg;

    // Register addresses on the serial bus
    localparam logic [7:0] ADDR_WIPER_0 = 8'h00;
    localparam logic [7:0] ADDR_WIPER_1 = 8'h01;
    localparam logic [7:0] ADDR_SHUTDOWN_CTRL = 8'h10;

    // Reset values and field layout
    localparam logic [7:0] WIPER_RESET = 8'h40;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam int RUN_BIT = 6;
    localparam logic [7:0] WIPER_MASK = 8'h7f;
    localparam int TAP_W = 7;
    localparam int CHANNELS = 2;

    // Identification byte: upper nibble is the device type code
    // Arbitrary value, not tied to any real part
    localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h5;
    localparam int ID_RW_BIT = 0;

    // System clock and derived timing
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int BROWNOUT_MIN_NS = 200;
    localparam int BROWNOUT_CYCLES_RAW =
        (BROWNOUT_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int BROWNOUT_CYCLES =
        (BROWNOUT_CYCLES_RAW < 1) ? 1 : BROWNOUT_CYCLES_RAW;
    localparam int POWERUP_NS = 1000;
    localparam int POWERUP_CYCLES_RAW =
        (POWERUP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int POWERUP_CYCLES =
        (POWERUP_CYCLES_RAW < 1) ? 1 : POWERUP_CYCLES_RAW;

    // Serial link states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ID,
        ST_ID_ACK,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } link_state_e;

    // One register write passed from the link side to the system side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } wr_req_s;

endpackage

/* File: tb/dual_pot_i2c_register_slave_tb.sv */
// Self-checking bench for the dual potentiometer register slave
`timescale 1ns/1ns
module dual_pot_i2c_register_slave_tb
    import dual_pot_pkg::*;
;
    localparam logic [6:0] MY_ID = {DEVICE_TYPE_DEFAULT, 3'h5};
    logic clock_in, sys_rst_in, brownout_in, ack;
    wire logic scl, m_oe, dut_oe, dut_sda, shut;
    wire logic [6:0] tap0, tap1;
    // Pull-up on the data line: low while either side pulls
    wire logic sda_line = ~(m_oe | (dut_oe & ~dut_sda));
    int fail_count = 0;
    int cmp_count = 0;
    i2c_master_model host (.scl_out(scl), .sda_oe_out(m_oe),
        .sda_in(sda_line));
    dual_pot_i2c_register_slave dut (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .scl_clk_in(scl), .sda_in(sda_line),
        .sda_out(dut_sda), .sda_oe_out(dut_oe), .addr_pin_2_in(1'b1),
        .addr_pin_1_in(1'b0), .addr_pin_0_in(1'b1),
        .brownout_in(brownout_in), .tap_sel_0_out(tap0),
        .tap_sel_1_out(tap1), .shutdown_out(shut));
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    task automatic chk(input string s, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_out(logic [7:0] e0, e1, logic sd);
        chk("tap_sel_0_out", e0, {1'b0, tap0});
        chk("tap_sel_1_out", e1, {1'b0, tap1});
        chk("shutdown_out", {7'h00, sd}, {7'h00, shut});
    endtask
    task automatic reg_write(logic [7:0] a, logic [7:0] d[$]);
        host.bus_start();
        host.put_byte({MY_ID, 1'b0}, ack);
        chk("id ack", 8'h01, {7'h00, ack});
        host.put_byte(a, ack);
        chk("addr ack", 8'h01, {7'h00, ack});
        foreach (d[i]) begin
            host.put_byte(d[i], ack);
            chk("data ack", 8'h01, {7'h00, ack});
        end
        host.bus_stop();
        repeat (6) @(negedge clock_in);
    endtask
    task automatic chk_read(logic [7:0] a, logic [7:0] e[$]);
        logic [7:0] b;
        host.bus_start();
        host.put_byte({MY_ID, 1'b0}, ack);
        host.put_byte(a, ack);
        host.bus_start();
        host.put_byte({MY_ID, 1'b1}, ack);
        chk("read id ack", 8'h01, {7'h00, ack});
        foreach (e[i]) begin
            host.get_byte(i == e.size() - 1, b);
            chk("read data", e[i], b);
        end
        host.bus_stop();
    endtask
    task automatic bad_id(logic [7:0] id);
        host.bus_start();
        host.put_byte(id, ack);
        chk("foreign id ack", 8'h00, {7'h00, ack});
        host.bus_stop();
    endtask
    task automatic brown_pulse();
        brownout_in = 1'b1;
        repeat (6) @(negedge clock_in);
        brownout_in = 1'b0;
        repeat (6) @(negedge clock_in);
    endtask
    task automatic t_power_up();
        chk_out(8'h40, 8'h40, 1'b0);
        chk("sda_oe_out", 8'h00, {7'h00, dut_oe});
        #2000;
        bad_id({MY_ID ^ 7'h01, 1'b0});
        chk_read(ADDR_WIPER_0, '{8'h40, 8'h40, 8'h40});
        $display("power-up test done");
    endtask
    task automatic t_write();
        reg_write(ADDR_WIPER_0, '{8'h00});
        chk_out(8'h00, 8'h40, 1'b0);
        reg_write(ADDR_WIPER_1, '{8'h7f});
        chk_out(8'h00, 8'h7f, 1'b0);
        reg_write(ADDR_WIPER_0, '{8'h11, 8'h22});
        chk_out(8'h11, 8'h22, 1'b0);
        chk_read(ADDR_WIPER_1, '{8'h22, 8'h40, 8'h11});
        bad_id({MY_ID ^ 7'h40, 1'b0});
        bad_id({MY_ID ^ 7'h02, 1'b1});
        // Abandoned write: address sent, no data, then stop
        host.bus_start();
        host.put_byte({MY_ID, 1'b0}, ack);
        host.put_byte(ADDR_WIPER_0, ack);
        host.bus_stop();
        chk_read(ADDR_WIPER_0, '{8'h11});
        reg_write(8'h05, '{8'h5a});
        chk_read(8'h05, '{8'h00});
        chk_out(8'h11, 8'h22, 1'b0);
        $display("write test done");
    endtask
    task automatic t_shutdown();
        reg_write(ADDR_SHUTDOWN_CTRL, '{8'hff});
        chk_read(ADDR_SHUTDOWN_CTRL, '{8'h40});
        chk_out(8'h11, 8'h22, 1'b0);
        brown_pulse();
        chk_out(8'h11, 8'h22, 1'b0);
        reg_write(ADDR_SHUTDOWN_CTRL, '{8'h00});
        chk("shutdown_out", 8'h01, {7'h00, shut});
        chk_read(ADDR_WIPER_0, '{8'h11, 8'h22, 8'h00});
        reg_write(ADDR_SHUTDOWN_CTRL, '{8'h40});
        chk_out(8'h11, 8'h22, 1'b0);
        reg_write(ADDR_SHUTDOWN_CTRL, '{8'hbf});
        brown_pulse();
        reg_write(ADDR_SHUTDOWN_CTRL, '{8'h40});
        chk_out(8'h40, 8'h40, 1'b0);
        chk_read(ADDR_WIPER_0, '{8'h40, 8'h40});
        $display("shutdown test done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        sys_rst_in = 1'b1;
        brownout_in = 1'b0;
        ack = 1'b0;
        repeat (2) @(negedge clock_in);
        sys_rst_in = 1'b0;
        @(negedge clock_in);
        t_power_up();
        t_write();
        t_shutdown();
        complete_run();
    end
    // Whole run needs well under 200 us of bus traffic
    initial begin
        #1000000;
        fail_count++;
        complete_run();
    end
endmodule

/* File: tb/dual_pot_monitor.sv */
// Port checker for the dual potentiometer register slave
`timescale 1ns/1ns
module dual_pot_monitor
    import dual_pot_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_DEFAULT
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic addr_pin_2_in,
    input wire logic addr_pin_1_in,
    input wire logic addr_pin_0_in,
    input wire logic brownout_in,
    input wire logic [TAP_W-1:0] tap_sel_0_out,
    input wire logic [TAP_W-1:0] tap_sel_1_out,
    input wire logic shutdown_out
);
    logic st_tog, st_seen, first, acc, rd;
    logic [3:0] bitn;
    logic [7:0] sh;
    wire logic [6:0] my_id = {DEVICE_TYPE, addr_pin_2_in,
        addr_pin_1_in, addr_pin_0_in};
    wire logic mid = tap_sel_0_out == 7'h40 && tap_sel_1_out == 7'h40;
    // A START cannot be seen on the serial clock, so it is flagged here
    always_ff @(negedge sda_in or posedge sys_rst_in) begin
        if (sys_rst_in) st_tog <= 1'b0;
        else if (scl_clk_in) st_tog <= ~st_tog;
    end
    always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_seen <= 1'b0;
            bitn <= 4'h0;
            first <= 1'b0;
            acc <= 1'b0;
            rd <= 1'b0;
            sh <= 8'h00;
        end else if (st_tog != st_seen) begin
            st_seen <= st_tog;
            bitn <= 4'h1;
            first <= 1'b1;
            sh <= {7'h00, sda_in};
        end else begin
            bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
            if (bitn != 4'h8) sh <= {sh[6:0], sda_in};
            if (bitn == 4'h8 && first) begin
                first <= 1'b0;
                acc <= sh[7:1] == my_id;
                rd <= sh[0];
            end
        end
    end
    sequence s_id_byte;
        first && bitn == 4'h8;
    endsequence
    sequence s_later_byte;
        !first && acc && bitn == 4'h8;
    endsequence
    sequence s_brown;
        (shutdown_out && brownout_in) [*2];
    endsequence
    a_ack_id: assert property (@(posedge scl_clk_in)
        disable iff (sys_rst_in) s_id_byte ##0 sh[7:1] == my_id |-> sda_oe_out)
        else $error("valid id byte not acknowledged");
    a_nack_id: assert property (@(posedge scl_clk_in)
        disable iff (sys_rst_in) s_id_byte ##0 sh[7:1] != my_id |-> !sda_oe_out)
        else $error("foreign id byte acknowledged");
    a_ack_write: assert property (@(posedge scl_clk_in)
        disable iff (sys_rst_in) s_later_byte ##0 !rd |-> sda_oe_out)
        else $error("write byte not acknowledged");
    a_rd_release: assert property (@(posedge scl_clk_in)
        disable iff (sys_rst_in) s_later_byte ##0 rd |-> !sda_oe_out)
        else $error("data line held in master ack slot");
    a_reset_vals: assert property (@(posedge clock_in)
        disable iff (sys_rst_in) $fell(sys_rst_in) |-> mid && !shutdown_out)
        else $error("outputs wrong after reset");
    a_oe_released: assert property (@(posedge clock_in)
        disable iff (sys_rst_in) $fell(sys_rst_in) |-> !sda_oe_out)
        else $error("data line driven after reset");
    a_brown_mid: assert property (@(posedge clock_in)
        disable iff (sys_rst_in) s_brown |-> ##[1:5] mid)
        else $error("brownout in shutdown left wipers off mid-scale");
    a_sda_zero: assert property (@(posedge clock_in)
        disable iff (sys_rst_in) sda_out == 1'b0)
        else $error("data line driven high");
endmodule
bind dual_pot_i2c_register_slave dual_pot_monitor #(
    .DEVICE_TYPE(DEVICE_TYPE)
) mon (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .scl_clk_in(scl_clk_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .addr_pin_2_in(addr_pin_2_in),
    .addr_pin_1_in(addr_pin_1_in),
    .addr_pin_0_in(addr_pin_0_in),
    .brownout_in(brownout_in),
    .tap_sel_0_out(tap_sel_0_out),
    .tap_sel_1_out(tap_sel_1_out),
    .shutdown_out(shutdown_out)
);

/* File: tb/i2c_master_model.sv */
// Bus master model driving frames into the register slave
`timescale 1ns/1ns
module i2c_master_model (
    output logic scl_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    // Long clock-low gap after each byte: the slave needs time per write
    int gap_ns = 400;
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic bus_start();
        sda_oe_out = 1'b0;
        #8 scl_out = 1'b1;
        #16 sda_oe_out = 1'b1;
        #16 scl_out = 1'b0;
    endtask
    // Clock is parked high after a stop and stands still
    task automatic bus_stop();
        #4 sda_oe_out = 1'b1;
        #12 scl_out = 1'b1;
        #16 sda_oe_out = 1'b0;
        #16;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #4 sda_oe_out = ~b[i];
            #12 scl_out = 1'b1;
            #16 scl_out = 1'b0;
        end
        #4 sda_oe_out = 1'b0;
        #12 scl_out = 1'b1;
        ack = ~sda_in;
        #16 scl_out = 1'b0;
        #(gap_ns);
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            #16 scl_out = 1'b1;
            b = {b[6:0], sda_in};
            #16 scl_out = 1'b0;
        end
        #4 sda_oe_out = ~last;
        #12 scl_out = 1'b1;
        #16 scl_out = 1'b0;
        #4 sda_oe_out = 1'b0;
        #(gap_ns);
    endtask
endmodule
